// *** rtl/dcc_defines.vh ***
// Purpose: shared constants of the disconnector command control block
// Assumes: 200 MHz system clock, millisecond timebase derived from it
// Notes: times are in milliseconds unless the name says cycles
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// clock and timebase
`define DCC_CLK_HZ 200000000
`define DCC_MS_PER_S 1000
`define DCC_CYCLES_PER_MS (`DCC_CLK_HZ / `DCC_MS_PER_S)

// fixed times
`define DCC_OPER_PULSE_MS 8'h96
`define DCC_MIN_EARLY_MS 16'h03e8

// setting ranges and defaults
`define DCC_PULSE_MIN_MS 16'h0064
`define DCC_PULSE_MAX_MS 16'hea60
`define DCC_PULSE_DEF_MS 16'h03e8
`define DCC_INTER_MIN_MS 16'h0014
`define DCC_INTER_MAX_MS 16'hea60
`define DCC_INTER_DEF_MS 16'h2710

// register byte offsets
`define DCC_ADDR_PULSE 8'h00
`define DCC_ADDR_INTER 8'h04
`define DCC_ADDR_CMD 8'h08
`define DCC_ADDR_STATUS 8'h0c
`define DCC_ADDR_OPCOUNT 8'h10

// command channel values
`define DCC_CMD_OFF 2'h0
`define DCC_CMD_ON 2'h1

// derived position state codes
`define DCC_ST_INTER 2'h0
`define DCC_ST_OFF 2'h1
`define DCC_ST_ON 2'h2
`define DCC_ST_BAD 2'h3

// status register fields
`define DCC_SB_STATE_LO 0
`define DCC_SB_STATE_HI 1
`define DCC_SB_OPENED 2
`define DCC_SB_CLOSED 3
`define DCC_SB_OPEN_CMD 4
`define DCC_SB_CLOSE_CMD 5
`define DCC_SB_DONE 6
`define DCC_SB_REFUSED 7

`endif

// *** rtl/dcc_tick.v ***
// Purpose: millisecond strobe from the system clock
// Assumes: CYCLES is the number of clocks per millisecond
// Notes: free running, so a timed interval may start up to 1 ms early
`timescale 1ns/1ps
`include "dcc_defines.vh"
module dcc_tick #(
  parameter CYCLES = `DCC_CYCLES_PER_MS
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  output reg tick
);
  reg [31:0] cnt;

  // divider, one-cycle strobe at wrap
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      if (cnt >= CYCLES - 1)
      begin
        cnt <= 32'h0;
        tick <= 1'b1;
      end
      else
      begin
        cnt <= cnt + 32'h1;
        tick <= 1'b0;
      end
    end
  end
endmodule

// *** rtl/dcc_pos_filter.v ***
// Purpose: filter the two position feedbacks into a four-value state
// Assumes: feedbacks synchronous to mclk, tick is a 1 ms strobe
// Notes: off/on/bad follow at once; intermediate waits wait_ms
`timescale 1ns/1ps
`include "dcc_defines.vh"
module dcc_pos_filter (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire tick,
  input wire open_position_feedback,
  input wire closed_position_feedback,
  input wire [15:0] wait_ms,
  output reg [1:0] derived_position_state,
  output reg settled_opened_flag,
  output reg settled_closed_flag,
  output reg status_event
);
  reg [15:0] wcnt;
  reg [1:0] next_state;
  reg [15:0] next_wcnt;
  wire [1:0] raw;

  // {on, off} is already the state encoding: 1 off, 2 on, 3 bad
  assign raw = {closed_position_feedback, open_position_feedback};

  // next state: hold the old state while intermediate is not yet due
  always @*
  begin
    next_state = derived_position_state;
    next_wcnt = wcnt;
    if (raw != `DCC_ST_INTER)
    begin
      next_state = raw;
      next_wcnt = 16'h0;
    end
    else if (derived_position_state != `DCC_ST_INTER && tick)
    begin
      if (wcnt + 16'h1 >= wait_ms)
      begin
        next_state = `DCC_ST_INTER;
        next_wcnt = 16'h0;
      end
      else
        next_wcnt = wcnt + 16'h1;
    end
  end

  // state, flags and change event
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      derived_position_state <= `DCC_ST_INTER;
      wcnt <= 16'h0;
      settled_opened_flag <= 1'b0;
      settled_closed_flag <= 1'b0;
      status_event <= 1'b0;
    end
    else if (ce)
    begin
      derived_position_state <= next_state;
      wcnt <= next_wcnt;
      settled_opened_flag <= (next_state == `DCC_ST_OFF);
      settled_closed_flag <= (next_state == `DCC_ST_ON);
      status_event <= (next_state != derived_position_state);
    end
  end
endmodule

// *** rtl/dcc_ctrl.v ***
// Purpose: command control of one motorised disconnector
// Assumes: all inputs synchronous to mclk; 1 ms timebase from mclk
// Notes: registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps
`include "dcc_defines.vh"
module dcc_ctrl #(
  parameter CYCLES_PER_MS = `DCC_CYCLES_PER_MS
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire front_panel_cmd_stb,
  input wire front_panel_cmd_on,
  input wire front_panel_permit,
  input wire supervisory_permit,
  input wire open_interlock_permit,
  input wire close_interlock_permit,
  input wire switching_inhibit,
  input wire open_position_feedback,
  input wire closed_position_feedback,
  output reg open_command_pulse,
  output reg close_command_pulse,
  output reg switching_done_pulse,
  output wire settled_closed_flag,
  output wire settled_opened_flag,
  output wire [1:0] derived_position_state,
  output wire status_event
);
  localparam FSM_IDLE = 2'h0;
  localparam FSM_OPEN = 2'h1;
  localparam FSM_CLOSE = 2'h2;

  reg [1:0] fsm;
  reg [15:0] pulse_ms;
  reg [15:0] inter_ms;
  reg [15:0] elapsed;
  reg [7:0] done_ms;
  reg [31:0] op_count;
  reg cmd_refused;
  wire tick;

  // command direction check: off needs open permit, on close permit
  function dir_ok;
    input [1:0] val;
    input open_p;
    input close_p;
    begin
      case (val)
        `DCC_CMD_OFF: dir_ok = open_p;
        `DCC_CMD_ON: dir_ok = close_p;
        default: dir_ok = 1'b0;
      endcase
    end
  endfunction

  // keep a setting inside its range rather than refuse the write
  function [15:0] clamp;
    input [31:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < {16'h0, lo})
        clamp = lo;
      else if (v > {16'h0, hi})
        clamp = hi;
      else
        clamp = v[15:0];
    end
  endfunction

  dcc_tick #(
    .CYCLES(CYCLES_PER_MS)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick)
  );

  dcc_pos_filter u_filter (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick),
    .open_position_feedback(open_position_feedback),
    .closed_position_feedback(closed_position_feedback),
    .wait_ms(inter_ms),
    .derived_position_state(derived_position_state),
    .settled_opened_flag(settled_opened_flag),
    .settled_closed_flag(settled_closed_flag),
    .status_event(status_event)
  );

  // request decode; the panel wins when both arrive in one cycle
  wire [1:0] panel_val = front_panel_cmd_on ? `DCC_CMD_ON : `DCC_CMD_OFF;
  wire sup_wr = wr && addr == `DCC_ADDR_CMD;
  wire any_req = front_panel_cmd_stb || sup_wr;
  wire [1:0] req_val = front_panel_cmd_stb ? panel_val : wdata[1:0];
  wire val_ok = front_panel_cmd_stb || wdata[31:2] == 30'h0;
  wire panel_ok = front_panel_cmd_stb && front_panel_permit
    && dir_ok(panel_val, open_interlock_permit, close_interlock_permit);
  wire sup_ok = !front_panel_cmd_stb && sup_wr && supervisory_permit
    && dir_ok(wdata[1:0], open_interlock_permit, close_interlock_permit);
  // one pulse at a time; a command during a pulse is refused
  wire accept = (panel_ok || (sup_ok && val_ok))
    && !switching_inhibit && fsm == FSM_IDLE;

  // early end allowed once the shorter of setting and 1000 ms has run
  wire [15:0] min_early = pulse_ms < `DCC_MIN_EARLY_MS ? pulse_ms : `DCC_MIN_EARLY_MS;
  wire success = (fsm == FSM_OPEN && derived_position_state == `DCC_ST_OFF)
    || (fsm == FSM_CLOSE && derived_position_state == `DCC_ST_ON);
  wire full_len = elapsed + 16'h1 >= pulse_ms;
  wire early_end = success && elapsed >= min_early;

  // a completed operation is a settled change into off or on
  wire op_done = status_event
    && (derived_position_state == `DCC_ST_OFF || derived_position_state == `DCC_ST_ON);

  // settings
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_ms <= `DCC_PULSE_DEF_MS;
      inter_ms <= `DCC_INTER_DEF_MS;
    end
    else if (ce && wr)
    begin
      if (addr == `DCC_ADDR_PULSE)
        pulse_ms <= clamp(wdata, `DCC_PULSE_MIN_MS, `DCC_PULSE_MAX_MS);
      if (addr == `DCC_ADDR_INTER)
        inter_ms <= clamp(wdata, `DCC_INTER_MIN_MS, `DCC_INTER_MAX_MS);
    end
  end

  // command pulse machine
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fsm <= FSM_IDLE;
      elapsed <= 16'h0;
      open_command_pulse <= 1'b0;
      close_command_pulse <= 1'b0;
    end
    else if (ce)
    begin
      case (fsm)
        FSM_IDLE:
        begin
          elapsed <= 16'h0;
          if (accept)
          begin
            if (req_val == `DCC_CMD_ON)
            begin
              fsm <= FSM_CLOSE;
              close_command_pulse <= 1'b1;
            end
            else
            begin
              fsm <= FSM_OPEN;
              open_command_pulse <= 1'b1;
            end
          end
        end
        FSM_OPEN, FSM_CLOSE:
        begin
          // early end is checked every cycle so it is not late by a tick
          if (early_end || (tick && full_len))
          begin
            fsm <= FSM_IDLE;
            open_command_pulse <= 1'b0;
            close_command_pulse <= 1'b0;
          end
          else if (tick)
            elapsed <= elapsed + 16'h1;
        end
        default:
        begin
          fsm <= FSM_IDLE;
          open_command_pulse <= 1'b0;
          close_command_pulse <= 1'b0;
        end
      endcase
    end
  end

  // done pulse, retriggered by a further operation
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switching_done_pulse <= 1'b0;
      done_ms <= 8'h0;
    end
    else if (ce)
    begin
      if (op_done)
      begin
        switching_done_pulse <= 1'b1;
        done_ms <= 8'h0;
      end
      else if (switching_done_pulse && tick)
      begin
        if (done_ms + 8'h1 >= `DCC_OPER_PULSE_MS)
          switching_done_pulse <= 1'b0;
        else
          done_ms <= done_ms + 8'h1;
      end
    end
  end

  // operation counter; a rise in the clear cycle still counts
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      op_count <= 32'h0;
    else if (ce)
    begin
      if (wr && addr == `DCC_ADDR_OPCOUNT)
        op_count <= {31'h0, op_done && !switching_done_pulse};
      else if (op_done && !switching_done_pulse)
        op_count <= op_count + 32'h1;
    end
  end

  // refused flag: set wins over the clear done by a status read
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_refused <= 1'b0;
    else if (ce)
    begin
      if (any_req && !accept)
        cmd_refused <= 1'b1;
      else if (rd && addr == `DCC_ADDR_STATUS)
        cmd_refused <= 1'b0;
    end
  end

  // read data, valid in the cycle after the strobe only
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else if (ce)
    begin
      rdata <= 32'h0;
      if (rd)
      begin
        case (addr)
          `DCC_ADDR_PULSE: rdata <= {16'h0, pulse_ms};
          `DCC_ADDR_INTER: rdata <= {16'h0, inter_ms};
          `DCC_ADDR_STATUS:
          begin
            rdata[`DCC_SB_STATE_HI:`DCC_SB_STATE_LO] <= derived_position_state;
            rdata[`DCC_SB_OPENED] <= settled_opened_flag;
            rdata[`DCC_SB_CLOSED] <= settled_closed_flag;
            rdata[`DCC_SB_OPEN_CMD] <= open_command_pulse;
            rdata[`DCC_SB_CLOSE_CMD] <= close_command_pulse;
            rdata[`DCC_SB_DONE] <= switching_done_pulse;
            rdata[`DCC_SB_REFUSED] <= cmd_refused;
          end
          `DCC_ADDR_OPCOUNT: rdata <= op_count;
          default: rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// *** sim/dcc_mech.sv ***
// Purpose: drive mechanism and position contacts beside the command block
// Assumes: a command pulse runs the drive for DLY cycles, then it stops
// Notes: fault 1 lifts both contacts, fault 2 shows both at once
`timescale 1ns/1ps
module dcc_mech #(
  parameter int DLY = 100
) (
  input wire logic mclk,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic [1:0] fault,
  output logic open_fb,
  output logic closed_fb
);
  logic opened = 1'b1;
  int cnt = 0;
  // travel only while a pulse asks for the other position
  always @(posedge mclk)
  begin
    if ((open_cmd && opened == 1'b0) || (close_cmd && opened == 1'b1))
      cnt <= cnt + 1;
    if (cnt == DLY)
    begin
      opened <= ~opened;
      cnt <= 0;
    end
  end
  // both contacts part in travel, so no stale position shows
  assign open_fb = fault == 2'h2 || (fault == 2'h0 && cnt == 0 && opened);
  assign closed_fb = fault == 2'h2 || (fault == 2'h0 && cnt == 0 && !opened);
endmodule

// *** sim/dcc_ctrl_chk.sv ***
// Purpose: port checks of the disconnector command block
// Assumes: single clock domain, reset active low
// Notes: lengths in cycles follow CYCLES_PER_MS
`timescale 1ns/1ps
module dcc_ctrl_chk #(
  parameter CYCLES_PER_MS = 10
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire front_panel_cmd_stb,
  input wire front_panel_cmd_on,
  input wire front_panel_permit,
  input wire supervisory_permit,
  input wire open_interlock_permit,
  input wire close_interlock_permit,
  input wire switching_inhibit,
  input wire open_position_feedback,
  input wire closed_position_feedback,
  input wire open_command_pulse,
  input wire close_command_pulse,
  input wire switching_done_pulse,
  input wire settled_closed_flag,
  input wire settled_opened_flag,
  input wire [1:0] derived_position_state,
  input wire status_event
);
  int pcnt;
  int dcnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // pulse lengths so far, cleared while low
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcnt <= 0;
      dcnt <= 0;
    end
    else
    begin
      pcnt <= (open_command_pulse || close_command_pulse) ? pcnt + 1 : 0;
      dcnt <= switching_done_pulse ? dcnt + 1 : 0;
    end
  end
  AST_FLAGS: assert property (settled_opened_flag == (derived_position_state == 2'h1) &&
    settled_closed_flag == (derived_position_state == 2'h2)) else $error("flag mismatch");
  AST_FB_OFF: assert property (ce && open_position_feedback && !closed_position_feedback
    |=> derived_position_state == 2'h1) else $error("off state missed");
  AST_FB_ON: assert property (ce && closed_position_feedback && !open_position_feedback
    |=> derived_position_state == 2'h2) else $error("on state missed");
  AST_EVT: assert property ($past(ce) |-> status_event ==
    (derived_position_state != $past(derived_position_state))) else $error("event wrong");
  AST_SRC_OPEN: assert property ($rose(open_command_pulse) |-> $past(open_interlock_permit &&
    !switching_inhibit && ((front_panel_cmd_stb && !front_panel_cmd_on && front_panel_permit) ||
    (wr && addr == 8'h08 && wdata == 32'h0 && supervisory_permit)))) else $error("bad open");
  AST_SRC_CLOSE: assert property ($rose(close_command_pulse) |-> $past(close_interlock_permit &&
    !switching_inhibit && ((front_panel_cmd_stb && front_panel_cmd_on && front_panel_permit) ||
    (wr && addr == 8'h08 && wdata == 32'h1 && supervisory_permit)))) else $error("bad close");
  AST_ACC: assert property (ce && front_panel_cmd_stb && front_panel_cmd_on && front_panel_permit
    && close_interlock_permit && !switching_inhibit && !open_command_pulse && !close_command_pulse
    |=> close_command_pulse) else $error("close not taken");
  AST_EXCL: assert property (!(open_command_pulse && close_command_pulse)) else $error("both");
  AST_PLEN: assert property ($fell(open_command_pulse || close_command_pulse)
    |-> pcnt >= 99 * CYCLES_PER_MS) else $error("command pulse short");
  AST_DONE: assert property ($rose(switching_done_pulse) |-> $past(status_event) &&
    ($past(derived_position_state) == 2'h1 || $past(derived_position_state) == 2'h2))
    else $error("done without operation");
  AST_DLEN: assert property ($fell(switching_done_pulse) |-> dcnt >= 149 * CYCLES_PER_MS)
    else $error("done pulse short");
endmodule
bind dcc_ctrl dcc_ctrl_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_dcc_ctrl_chk (.*);

// *** sim/dcc_ctrl_tb.sv ***
// Purpose: self-checking bench of the disconnector command block
// Assumes: one ms is shortened to C cycles
// Notes: mechanism model starts in the opened position
`timescale 1ns/1ps
module dcc_ctrl_tb;
  localparam int C = 10;
  logic mclk, rst_n, ce, wr, rd, front_panel_cmd_stb, front_panel_cmd_on, switching_inhibit;
  logic front_panel_permit, supervisory_permit, open_interlock_permit, close_interlock_permit;
  logic open_position_feedback, closed_position_feedback, open_command_pulse, status_event;
  logic close_command_pulse, switching_done_pulse, settled_closed_flag, settled_opened_flag;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] derived_position_state, fault;
  logic [4:0] pv [6] = '{5'h0e, 5'h1c, 5'h1a, 5'h1f, 5'h16, 5'h1e};
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  dcc_ctrl #(.CYCLES_PER_MS(C)) u_dcc_ctrl (.*);
  dcc_mech #(.DLY(10 * C)) u_dcc_mech (.mclk(mclk), .open_cmd(open_command_pulse),
    .close_cmd(close_command_pulse), .fault(fault), .open_fb(open_position_feedback),
    .closed_fb(closed_position_feedback));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // hang guard, the run needs about 16200 cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic panel(input logic on);
    @(posedge mclk);
    front_panel_cmd_stb <= 1'b1;
    front_panel_cmd_on <= on;
    @(posedge mclk);
    front_panel_cmd_stb <= 1'b0;
  endtask
  // cycles until both command pulses are low
  task automatic plen(output int k);
    k = 0;
    while (open_command_pulse || close_command_pulse)
    begin
      @(posedge mclk);
      #1 k++;
    end
  endtask
  initial
  begin
    {rst_n, wr, rd, front_panel_cmd_stb, front_panel_cmd_on, fault} = 7'h00;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    {front_panel_permit, supervisory_permit, open_interlock_permit, close_interlock_permit,
      switching_inhibit} = 5'h1e;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rreg(8'h00, 32'h3e8);
    rreg(8'h04, 32'h2710);
    rreg(8'h20, 32'h0);
    wreg(8'h00, 32'h32);
    rreg(8'h00, 32'h64);
    wreg(8'h04, 32'h14);
    // settling into off after reset counts as one operation
    repeat (1700) @(posedge mclk);
    #1 chk(derived_position_state, 2'h1);
    rreg(8'h10, 32'h1);
    wreg(8'h10, 32'h0);
    rreg(8'h10, 32'h0);
    // each case lacks one permit, sets the inhibit or sends a bad value
    for (int i = 0; i < 6; i++)
    begin
      @(posedge mclk);
      {front_panel_permit, supervisory_permit, open_interlock_permit, close_interlock_permit,
        switching_inhibit} <= pv[i];
      if (i < 4)
        panel(i != 2);
      else
        wreg(8'h08, 32'(i - 3));
      repeat (3) @(posedge mclk);
      #1 chk({open_command_pulse, close_command_pulse}, 2'h0);
    end
    panel(1'b1);
    #1 chk(close_command_pulse, 1'b1);
    panel(1'b0);
    #1 chk(open_command_pulse, 1'b0);
    plen(n);
    chk(n >= 99 * C - 5 && n <= 100 * C + 1, 1'b1);
    chk({settled_closed_flag, settled_opened_flag, derived_position_state}, 4'ha);
    // status: closed, done pulse standing, refusals still sticky, then cleared by the read
    rreg(8'h0c, 32'hca);
    rreg(8'h0c, 32'h4a);
    repeat (1600) @(posedge mclk);
    rreg(8'h10, 32'h1);
    // long setting, so success must cut the pulse at the floor
    wreg(8'h00, 32'h5dc);
    wreg(8'h08, 32'h0);
    #1 chk(open_command_pulse, 1'b1);
    plen(n);
    chk(n >= 1000 * C - 20 && n <= 1000 * C + 20, 1'b1);
    chk({settled_closed_flag, settled_opened_flag, derived_position_state}, 4'h5);
    repeat (1600) @(posedge mclk);
    rreg(8'h10, 32'h2);
    @(posedge mclk);
    fault <= 2'h1;
    repeat (10 * C) @(posedge mclk);
    #1 chk(derived_position_state, 2'h1);
    repeat (15 * C) @(posedge mclk);
    #1 chk(derived_position_state, 2'h0);
    @(posedge mclk);
    fault <= 2'h2;
    repeat (3) @(posedge mclk);
    #1 chk(derived_position_state, 2'h3);
    rreg(8'h10, 32'h2);
    // a write while the clock enable is low must leave the setting alone
    @(posedge mclk);
    ce <= 1'b0;
    wreg(8'h00, 32'h3e8);
    @(posedge mclk);
    ce <= 1'b1;
    rreg(8'h00, 32'h5dc);
    conclude();
  end
endmodule
